// File: bench/cbmc_host.sv
/*
 * host processor model: control bits and write strobes.
 * assumes the bench calls its tasks from one process at a time.
 */
`timescale 1ns/1ps
`default_nettype none
module cbmc_host (
    input  wire logic clock,
    output var logic  charge_disable_bit,
    output var logic  hiz_request_bit,
    output var logic  stat_enable_bit,
    output var logic  param_reset_wr,
    output var logic  boost_select_wr,
    output var logic  boost_select_val,
    output var logic  watchdog_restart_wr,
    output var logic  fault_clear_wr
);
initial begin
    {charge_disable_bit, hiz_request_bit, stat_enable_bit} = 3'h0;
    {param_reset_wr, boost_select_wr, boost_select_val} = 3'h0;
    {watchdog_restart_wr, fault_clear_wr} = 2'h0;
end
task set_lv(input logic cd, input logic hz, input logic en);
    @(posedge clock);
    charge_disable_bit <= cd;
    hiz_request_bit <= hz;
    stat_enable_bit <= en;
endtask
// one-cycle write; param reset issued in whatever mode the top is in
task strobe(input int k, input logic v);
    @(posedge clock);
    case (k)
        0: param_reset_wr <= 1'h1;
        1: begin
            boost_select_wr <= 1'h1;
            boost_select_val <= v;
        end
        2: watchdog_restart_wr <= 1'h1;
        default: fault_clear_wr <= 1'h1;
    endcase
    @(posedge clock);
    {param_reset_wr, boost_select_wr, watchdog_restart_wr} <= 3'h0;
    fault_clear_wr <= 1'h0;
endtask
endmodule
`default_nettype wire

// File: bench/cbmc_top_props.sv
/*
 * concurrent checks on the ports of the charger boost mode control top.
 * assumes the mode and fault codes of cbmc_regs.vh, one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cbmc_regs.vh"
module cbmc_chk (
    input wire logic                    clock,
    input wire logic                    resetn,
    input wire logic                    charge_disable_bit,
    input wire logic                    param_reset_wr,
    input wire logic                    boost_select_wr,
    input wire logic                    hiz_request_bit,
    input wire logic                    watchdog_restart_wr,
    input wire logic                    stat_enable_bit,
    input wire logic                    boost_request_pin,
    input wire logic                    vbus_above_uvlo,
    input wire logic                    vbus_overvoltage,
    input wire logic                    bat_above_over_threshold,
    input wire logic                    bat_below_min,
    input wire logic                    charging_active,
    input wire logic                    inductor_below_75ma,
    input wire logic                    mid_rail_node_low,
    input wire logic [`CBMC_MODE_W-1:0] mode,
    input wire logic                    charge_enable,
    input wire logic                    boost_switching,
    input wire logic                    param_defaults,
    input wire logic                    param_reset_bit,
    input wire logic                    boost_select_bit,
    input wire logic                    watchdog_restart_bit,
    input wire logic [`CBMC_FLT_W-1:0]  fault_status,
    input wire logic                    minute32_mode,
    input wire logic                    stat_out,
    input wire logic                    stat_oe
);
default clocking @(posedge clock); endclocking
default disable iff (!resetn);
wire logic boosting = (mode == `CBMC_MODE_BOOST);
////////////////////////////////////////////////////////////////////////////
property p_hiz;
    hiz_request_bit && !boost_request_pin |=> mode == `CBMC_MODE_HIZ;
endproperty
a_hiz: assert property (p_hiz) else $error("hiz request ignored");
property p_chg_dis;
    charge_disable_bit |=> !charge_enable;
endproperty
a_chg_dis: assert property (p_chg_dis) else $error("charging while off");
property p_prst;
    param_reset_wr ##1 !param_reset_wr |->
        param_defaults && param_reset_bit ##1 !param_reset_bit;
endproperty
a_prst: assert property (p_prst) else $error("param reset wrong");
property p_wd;
    watchdog_restart_wr ##1 !watchdog_restart_wr |->
        watchdog_restart_bit ##1 !watchdog_restart_bit;
endproperty
a_wd: assert property (p_wd) else $error("restart bit stuck");
property p_ov;
    boosting && vbus_overvoltage && fault_status == `CBMC_FLT_NONE
        && !boost_select_wr |=>
        fault_status == `CBMC_FLT_VBUS_OV && !boost_select_bit;
endproperty
a_ov: assert property (p_ov) else $error("bus overvoltage missed");
property p_bat;
    boosting && (bat_above_over_threshold || bat_below_min) && !vbus_overvoltage
        && fault_status == `CBMC_FLT_NONE && !boost_select_wr |=>
        fault_status == `CBMC_FLT_BAT && !boost_select_bit;
endproperty
a_bat: assert property (p_bat) else $error("battery fault missed");
property p_pulse;
    fault_status != `CBMC_FLT_NONE && $past(fault_status) == `CBMC_FLT_NONE
        |-> ##2 (stat_oe && !stat_out) [*8];
endproperty
a_pulse: assert property (p_pulse) else $error("no fault pulse");
property p_stat;
    (mode == `CBMC_MODE_CHARGE && charging_active && stat_enable_bit) [*2]
        |-> stat_oe && !stat_out;
endproperty
a_stat: assert property (p_stat) else $error("status not low");
property p_pfm;
    boosting && inductor_below_75ma && !mid_rail_node_low
        |-> ##2 !boost_switching;
endproperty
a_pfm: assert property (p_pfm) else $error("no pulse skip");
property p_m32;
    minute32_mode && !vbus_above_uvlo |=> mode == `CBMC_MODE_HIZ;
endproperty
a_m32: assert property (p_m32) else $error("hiz missed in minute mode");
endmodule
bind cbmc_top cbmc_chk u_chk (.*);
`default_nettype wire

// File: bench/tb_cbmc_top.sv
/*
 * self-checking bench for the charger boost mode control top.
 * assumes cbmc_host drives the host bits; long timers are not reached.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cbmc_regs.vh"
module tb_cbmc_top;
logic clock, resetn, vbus_above_uvlo, charge_fault, vbus_overvoltage;
logic vbus_overload, bat_above_over_threshold, bat_below_min;
logic bat_below_low_threshold, charging_active, inductor_below_75ma;
logic mid_rail_node_low, boost_request_pin;
wire logic charge_disable_bit, param_reset_wr, boost_select_wr;
wire logic boost_select_val, hiz_request_bit, watchdog_restart_wr;
wire logic fault_clear_wr, stat_enable_bit, charge_enable, boost_enable;
wire logic boost_switching, hiz_enable, current_limit_fet, param_defaults;
wire logic param_reset_bit, boost_select_bit, watchdog_restart_bit;
wire logic minute32_mode, stat_out, stat_oe;
wire logic [`CBMC_MODE_W-1:0] mode;
wire logic [`CBMC_FLT_W-1:0]  fault_status;
// open-drain status wire with the host's pull-up
wire logic stat_pin = stat_oe ? stat_out : 1'h1;
int fails, n_compared, cyc;
cbmc_host host (.*);
cbmc_top dut (.*);
////////////////////////////////////////////////////////////////////////////
initial begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
end
task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
        fails++;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask
task wt(input int n);
    repeat (n) @(posedge clock);
    #1;
endtask
task print_verdict;
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
endtask
// width of the low pulse on the status wire, in clock cycles
task t_pulse;
    int n;
    n = 0;
    for (int k = 0; k < 4 && stat_pin !== 1'h0; k++) wt(1);
    while (stat_pin === 1'h0 && n < 6000) begin
        wt(1);
        n++;
    end
    chk(n, 32'h0000_1400);
endtask
////////////////////////////////////////////////////////////////////////////
task t_charge;
    host.set_lv(1'h0, 1'h0, 1'h1);
    vbus_above_uvlo <= 1'h1;
    charging_active <= 1'h1;
    wt(3);
    chk(mode, `CBMC_MODE_CHARGE);
    chk(charge_enable, 1'h1);
    chk(stat_pin, 1'h0);
    host.set_lv(1'h0, 1'h0, 1'h0);
    charge_fault <= 1'h1;
    wt(3);
    chk(mode, `CBMC_MODE_CHGCFG);
    chk(stat_pin, 1'h1);
    @(posedge clock);
    charge_fault <= 1'h0;
    vbus_above_uvlo <= 1'h0;
    wt(3);
    chk(mode, `CBMC_MODE_HIZ);
    chk(minute32_mode, 1'h0);
    host.set_lv(1'h1, 1'h0, 1'h1);
    vbus_above_uvlo <= 1'h1;
    wt(3);
    chk(charge_enable, 1'h0);
    charging_active <= 1'h0;
    host.strobe(0, 1'h1);
    #1;
    chk({param_defaults, param_reset_bit}, 2'h3);
    wt(1);
    chk(param_reset_bit, 1'h0);
    host.set_lv(1'h0, 1'h0, 1'h1);
endtask
task t_boost;
    host.strobe(1, 1'h1);
    wt(2);
    chk(mode, `CBMC_MODE_BOOST);
    inductor_below_75ma <= 1'h1;
    wt(2);
    chk(boost_switching, 1'h0);
    {inductor_below_75ma, mid_rail_node_low} <= 2'h1;
    wt(2);
    chk(boost_switching, 1'h1);
    host.strobe(2, 1'h1);
    #1;
    chk(watchdog_restart_bit, 1'h1);
    wt(1);
    chk(watchdog_restart_bit, 1'h0);
    vbus_overload <= 1'h1;
    wt(2000);
    chk({current_limit_fet, fault_status}, 4'h8);
    vbus_overload <= 1'h0;
    @(posedge clock);
    vbus_overvoltage <= 1'h1;
    wt(2);
    chk({boost_select_bit, fault_status}, 4'h2);
    chk(mode, `CBMC_MODE_CHGCFG);
    t_pulse();
    vbus_overvoltage <= 1'h0;
    wt(10);
    chk(boost_enable, 1'h0);
    host.strobe(3, 1'h0);
    host.strobe(1, 1'h1);
    wt(3);
    chk(mode, `CBMC_MODE_BOOST);
    bat_below_min <= 1'h1;
    wt(2);
    chk({boost_select_bit, fault_status}, 4'h4);
    t_pulse();
    bat_below_min <= 1'h0;
    host.strobe(3, 1'h0);
endtask
task t_pin;
    host.set_lv(1'h0, 1'h1, 1'h1);
    boost_request_pin <= 1'h1;
    wt(4);
    chk(mode, `CBMC_MODE_BOOST);
    boost_request_pin <= 1'h0;
    wt(3);
    chk({mode, hiz_enable}, 3'h1);
endtask
////////////////////////////////////////////////////////////////////////////
always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
        fails++;
        print_verdict();
    end
end
initial begin
    {fails, n_compared, cyc} = 0;
    resetn = 1'h0;
    {vbus_above_uvlo, charge_fault, vbus_overvoltage, vbus_overload} = 4'h0;
    {bat_above_over_threshold, bat_below_min, bat_below_low_threshold} = 3'h0;
    {charging_active, inductor_below_75ma, mid_rail_node_low} = 3'h0;
    boost_request_pin = 1'h0;
    repeat (4) @(posedge clock);
    resetn <= 1'h1;
    wt(1);
    chk({mode, hiz_enable, charge_enable, boost_enable}, 5'h04);
    t_charge();
    t_boost();
    t_pin();
    print_verdict();
end
endmodule
`default_nettype wire

// File: hw/cbmc_pulse.v
/*
 * fixed-width low pulse generator for the open-drain status pin.
 * assumes one clock, synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cbmc_regs.vh"

module cbmc_pulse (
    input  wire clock,
    input  wire resetn,
    input  wire fire,
    output reg  busy
);
    reg [`CBMC_CNT_W-1:0] count_r;

    always @(posedge clock) begin
        if (!resetn) begin
            count_r <= {`CBMC_CNT_W{1'b0}};
            busy    <= 1'b0;
        end else if (fire && !busy) begin
            count_r <= `CBMC_PULSE_CYC - 32'h0000_0001;
            busy    <= 1'b1;
        end else if (busy) begin
            if (count_r == {`CBMC_CNT_W{1'b0}})
                busy <= 1'b0;
            else
                count_r <= count_r - 32'h0000_0001;
        end
    end
endmodule
`default_nettype wire

// File: hw/cbmc_regs.vh
/*
 * timing constants, mode codes and fault cause codes for the charger
 * boost mode control block.
 * assumes a 40 MHz system clock; included by bare name.
 */
`ifndef CBMC_REGS_VH
`define CBMC_REGS_VH

`define CBMC_CLK_HZ           40000000
// times in their own units
`define CBMC_PULSE_US         128
`define CBMC_OVLD_MS          30
`define CBMC_BOOST_WD_S       32
`define CBMC_CRUDE_S          32
// derived cycle counts (clock ratios truncated by integer division)
`define CBMC_PULSE_CYC  ((`CBMC_PULSE_US * (`CBMC_CLK_HZ / 1000000)))
`define CBMC_OVLD_CYC   ((`CBMC_OVLD_MS * (`CBMC_CLK_HZ / 1000)))
`define CBMC_WD_CYC     ((`CBMC_BOOST_WD_S * `CBMC_CLK_HZ))
`define CBMC_CRUDE_CYC  ((`CBMC_CRUDE_S * `CBMC_CLK_HZ))
`define CBMC_CNT_W            32

// operating modes
`define CBMC_MODE_W           2
`define CBMC_MODE_HIZ         2'h0
`define CBMC_MODE_CHGCFG      2'h1
`define CBMC_MODE_CHARGE      2'h2
`define CBMC_MODE_BOOST       2'h3

// fault cause codes
`define CBMC_FLT_W            3
`define CBMC_FLT_NONE         3'h0
`define CBMC_FLT_TIMER        3'h1
`define CBMC_FLT_VBUS_OV      3'h2
`define CBMC_FLT_OVLD         3'h3
`define CBMC_FLT_BAT          3'h4

`endif

// File: hw/cbmc_timer.v
/*
 * restartable up-counter with an expiry pulse.
 * assumes one clock, synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cbmc_regs.vh"

module cbmc_timer (
    input  wire                   clock,
    input  wire                   resetn,
    input  wire                   run,
    input  wire                   restart,
    input  wire [`CBMC_CNT_W-1:0] limit,
    output reg                    expired
);
    reg [`CBMC_CNT_W-1:0] count_r;

    always @(posedge clock) begin
        if (!resetn || restart || !run) begin
            count_r <= {`CBMC_CNT_W{1'b0}};
            expired <= 1'b0;
        end else if (count_r >= limit - 32'h0000_0001) begin
            // single pulse, then restart from zero
            count_r <= {`CBMC_CNT_W{1'b0}};
            expired <= 1'b1;
        end else begin
            count_r <= count_r + 32'h0000_0001;
            expired <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: hw/cbmc_top.v
/*
 * supervisory mode and fault logic of a one-cell charger with boost.
 * chooses charge, charge-configure, boost or high impedance; runs the
 * boost watchdog, overload qualification, crude timer and status pulse.
 * assumes the host bits arrive as plain ports synchronous to clock;
 * analog comparators are already synchronised levels.
 */
//
// Behaviour
// - charge only while charge-disable is 0
// - parameter reset restores defaults then self-clears
// - select 0, hiz 0: charge, configure on fault, hiz below lockout
// - select 1, hiz 0: boost without boost fault, configure on boost fault
// - hiz request with boost pin inactive gives high impedance
// - outside 32-minute mode boost pin or select bit starts boost
// - light load: stop switching under 75 mA, resume near 99.5% rail
// - boost start launches 32-second watchdog
// - watchdog restart bit restarts timer and self-clears
// - watchdog expiry stops boost, pulses status, sets fault bits
// - watchdog fault holds until reset or host clear
// - bus overvoltage stops boost, clears select, flags, pulses
// - after overvoltage restart needs select set or boost pin active
// - overload declared only after more than 30 ms continuous
// - overload fault stops boost until host clears fault
// - battery out of range stops boost, clears select, flags, pulses
// - status released while boosting, one 128 us low pulse on fault
// - crude 32-second timer runs in hiz while battery is low
// - crude expiry enters 32-minute mode and stops crude timer
// - 32-minute mode: hiz whenever bus below lockout
// - charge mode: status low while charging and enable bit set
//
`timescale 1ns/1ps
`default_nettype none
`include "cbmc_regs.vh"

module cbmc_top (
    input  wire                   clock,
    input  wire                   resetn,
    // host control bits
    input  wire                   charge_disable_bit,
    input  wire                   param_reset_wr,
    input  wire                   boost_select_wr,
    input  wire                   boost_select_val,
    input  wire                   hiz_request_bit,
    input  wire                   watchdog_restart_wr,
    input  wire                   fault_clear_wr,
    input  wire                   stat_enable_bit,
    // pins and analog comparators
    input  wire                   boost_request_pin,
    input  wire                   vbus_above_uvlo,
    input  wire                   charge_fault,
    input  wire                   vbus_overvoltage,
    input  wire                   vbus_overload,
    input  wire                   bat_above_over_threshold,
    input  wire                   bat_below_min,
    input  wire                   bat_below_low_threshold,
    input  wire                   charging_active,
    input  wire                   inductor_below_75ma,
    input  wire                   mid_rail_node_low,
    // outputs
    output reg  [`CBMC_MODE_W-1:0] mode,
    output reg                    charge_enable,
    output reg                    boost_enable,
    output reg                    boost_switching,
    output reg                    hiz_enable,
    output reg                    current_limit_fet,
    output reg                    param_defaults,
    output reg                    param_reset_bit,
    output reg                    boost_select_bit,
    output reg                    watchdog_restart_bit,
    output reg  [`CBMC_FLT_W-1:0] fault_status,
    output reg                    minute32_mode,
    output reg                    stat_out,
    output reg                    stat_oe
);
    ////////////////////////////////////////////////////////////////////
    reg  [`CBMC_MODE_W-1:0] mode_nxt;
    reg                     boost_fault_r;
    reg                     pfm_idle_r;
    reg                     ovld_seen_r;
    wire                    wd_expired;
    wire                    ovld_expired;
    wire                    crude_expired;
    wire                    pulse_busy;
    reg                     fire_r;
    wire                    bat_bad;
    wire                    boosting;
    wire [`CBMC_FLT_W-1:0]  fault_now;

    // one decode of the mode code, shared by enables, timers and pin
    function mode_is;
        input [`CBMC_MODE_W-1:0] m;
        input [`CBMC_MODE_W-1:0] code;
        begin
            mode_is = (m == code);
        end
    endfunction

    // one boost fault per cycle; priority settles simultaneous causes
    function [`CBMC_FLT_W-1:0] fault_pick;
        input wd_hit;
        input ov_hit;
        input ovld_hit;
        input bat_hit;
        begin
            if (wd_hit)
                fault_pick = `CBMC_FLT_TIMER;
            else if (ov_hit)
                fault_pick = `CBMC_FLT_VBUS_OV;
            else if (ovld_hit)
                fault_pick = `CBMC_FLT_OVLD;
            else if (bat_hit)
                fault_pick = `CBMC_FLT_BAT;
            else
                fault_pick = `CBMC_FLT_NONE;
        end
    endfunction

    assign bat_bad  = bat_above_over_threshold | bat_below_min;
    assign boosting = mode_is(mode, `CBMC_MODE_BOOST);
    assign fault_now = fault_pick(wd_expired, vbus_overvoltage,
                                  ovld_expired, bat_bad);

    ////////////////////////////////////////////////////////////////////
    // mode selection
    always @* begin
        mode_nxt = `CBMC_MODE_HIZ;
        if (minute32_mode && !vbus_above_uvlo)
            mode_nxt = `CBMC_MODE_HIZ;
        else if (hiz_request_bit && !boost_request_pin)
            mode_nxt = `CBMC_MODE_HIZ;
        else if ((boost_select_bit || boost_request_pin) && !minute32_mode)
            mode_nxt = boost_fault_r ? `CBMC_MODE_CHGCFG
                                     : `CBMC_MODE_BOOST;
        else if (!vbus_above_uvlo)
            mode_nxt = `CBMC_MODE_HIZ;
        // a boost fault keeps the charger configuring until it heals or the host clears it
        else if (charge_fault || charge_disable_bit || boost_fault_r)
            mode_nxt = `CBMC_MODE_CHGCFG;
        else
            mode_nxt = `CBMC_MODE_CHARGE;
    end

    always @(posedge clock) begin
        if (!resetn) begin
            mode              <= `CBMC_MODE_HIZ;
            charge_enable     <= 1'b0;
            boost_enable      <= 1'b0;
            hiz_enable        <= 1'b1;
            current_limit_fet <= 1'b0;
        end else begin
            mode              <= mode_nxt;
            charge_enable     <= mode_is(mode_nxt, `CBMC_MODE_CHARGE);
            boost_enable      <= mode_is(mode_nxt, `CBMC_MODE_BOOST);
            hiz_enable        <= mode_is(mode_nxt, `CBMC_MODE_HIZ);
            // input fet limits current while overload is unqualified
            current_limit_fet <= boosting && vbus_overload;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // light-load pulse skipping
    always @(posedge clock) begin
        if (!resetn) begin
            pfm_idle_r      <= 1'b0;
            boost_switching <= 1'b0;
        end else begin
            // while idle the coil carries no current, so only the
            // mid-rail comparator may wake the converter again
            if (!boosting)
                pfm_idle_r <= 1'b0;
            else if (pfm_idle_r) begin
                if (mid_rail_node_low)
                    pfm_idle_r <= 1'b0;
            end else if (inductor_below_75ma)
                pfm_idle_r <= 1'b1;
            boost_switching <= boosting && !pfm_idle_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // timers: boost watchdog, overload qualification, crude timer
    cbmc_timer u_wd (
        .clock   (clock),
        .resetn  (resetn),
        .run     (boosting),
        .restart (watchdog_restart_bit),
        .limit   (`CBMC_WD_CYC),
        .expired (wd_expired)
    );

    cbmc_timer u_ovld (
        .clock   (clock),
        .resetn  (resetn),
        .run     (boosting && vbus_overload),
        .restart (1'b0),
        .limit   (`CBMC_OVLD_CYC),
        .expired (ovld_expired)
    );

    cbmc_timer u_crude (
        .clock   (clock),
        .resetn  (resetn),
        .run     (mode_is(mode, `CBMC_MODE_HIZ) && bat_below_low_threshold
                  && !minute32_mode),
        .restart (1'b0),
        .limit   (`CBMC_CRUDE_CYC),
        .expired (crude_expired)
    );

    ////////////////////////////////////////////////////////////////////
    // host bits and faults
    always @(posedge clock) begin
        if (!resetn) begin
            param_reset_bit      <= 1'b0;
            param_defaults       <= 1'b0;
            boost_select_bit     <= 1'b0;
            watchdog_restart_bit <= 1'b0;
            fault_status         <= `CBMC_FLT_NONE;
            boost_fault_r        <= 1'b0;
            ovld_seen_r          <= 1'b0;
            minute32_mode        <= 1'b0;
            fire_r               <= 1'b0;
        end else begin
            fire_r <= 1'b0;
            // defaults pulse one cycle, then the bit self-clears
            param_defaults  <= param_reset_wr;
            param_reset_bit <= param_reset_wr;
            watchdog_restart_bit <= watchdog_restart_wr;
            if (crude_expired)
                minute32_mode <= 1'b1;
            if (boost_select_wr)
                boost_select_bit <= boost_select_val;
            // voltage faults heal once levels return; overload and
            // watchdog faults need host clear
            if (fault_clear_wr) begin
                fault_status  <= `CBMC_FLT_NONE;
                ovld_seen_r   <= 1'b0;
                boost_fault_r <= 1'b0;
            end else if (!ovld_seen_r &&
                         fault_status != `CBMC_FLT_TIMER &&
                         !vbus_overvoltage && !bat_bad)
                boost_fault_r <= 1'b0;
            // a latched fault masks later causes until healed or cleared
            if (boosting && !boost_fault_r) begin
                if (fault_now == `CBMC_FLT_TIMER) begin
                    fault_status  <= `CBMC_FLT_TIMER;
                    boost_fault_r <= 1'b1;
                    fire_r        <= 1'b1;
                end else if (fault_now == `CBMC_FLT_VBUS_OV) begin
                    fault_status     <= `CBMC_FLT_VBUS_OV;
                    boost_select_bit <= 1'b0;
                    boost_fault_r    <= 1'b1;
                    fire_r           <= 1'b1;
                end else if (fault_now == `CBMC_FLT_OVLD) begin
                    fault_status     <= `CBMC_FLT_OVLD;
                    boost_select_bit <= 1'b0;
                    boost_fault_r    <= 1'b1;
                    ovld_seen_r      <= 1'b1;
                    fire_r           <= 1'b1;
                end else if (fault_now == `CBMC_FLT_BAT) begin
                    fault_status     <= `CBMC_FLT_BAT;
                    boost_select_bit <= 1'b0;
                    boost_fault_r    <= 1'b1;
                    fire_r           <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // status pin, open drain: drives low or releases
    cbmc_pulse u_pulse (
        .clock  (clock),
        .resetn (resetn),
        .fire   (fire_r),
        .busy   (pulse_busy)
    );

    always @(posedge clock) begin
        if (!resetn) begin
            stat_out <= 1'b0;
            stat_oe  <= 1'b0;
        end else begin
            stat_out <= 1'b0;
            // a fault pulse overrides the charge indication
            stat_oe  <= pulse_busy ||
                        (mode_is(mode, `CBMC_MODE_CHARGE) && charging_active
                         && stat_enable_bit);
        end
    end
endmodule
`default_nettype wire
